// ---- logic/frd_pkg.sv ----
// Constants and types shared by the front-side bus request decoder
package frd_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] FRD_REG_CTRL = 8'h00;
  localparam logic [7:0] FRD_REG_FIRST_ERR = 8'h04;
  localparam logic [7:0] FRD_REG_NEXT_ERR = 8'h08;
  localparam logic [7:0] FRD_REG_STATUS = 8'h0c;

  // Control fields
  localparam int FRD_CTRL_EN_BIT = 0;
  localparam int FRD_CTRL_DEFER_BIT = 1;
  localparam int FRD_CTRL_SMM_CACHE_BIT = 2;
  localparam logic [2:0] FRD_CTRL_RESET = 3'h3;

  // Error fields, shared by first and subsequent error registers
  localparam int FRD_ERR_W = 4;
  localparam int FRD_ERR_F4 = 0;
  localparam int FRD_ERR_F8 = 1;
  localparam int FRD_ERR_UNSUP = 2;
  localparam int FRD_ERR_SYM = 3;

  // ****************************************
  // Request codes, first request phase
  // ****************************************
  localparam logic [2:0] FRD_MEM_RD_INV = 3'h2;
  localparam logic [2:0] FRD_MEM_RD_CODE = 3'h4;
  localparam logic [2:0] FRD_MEM_RD_DATA = 3'h6;
  localparam logic [2:0] FRD_MEM_WR_LINE = 3'h7;
  localparam logic [2:0] FRD_MEM_WR_INV = 3'h5;
  localparam logic [2:0] FRD_MEM_BRANCH = 3'h3;
  localparam logic [4:0] FRD_CODE_DEFER_REPLY = 5'h00;
  localparam logic [4:0] FRD_CODE_SPECIAL = 5'h01;
  localparam logic [4:0] FRD_CODE_INT_ACK = 5'h08;
  localparam logic [4:0] FRD_CODE_INT = 5'h09;
  localparam logic [4:0] FRD_CODE_IO_RD = 5'h10;
  localparam logic [4:0] FRD_CODE_IO_WR = 5'h11;
  localparam logic [4:0] FRD_CODE_RSV_RD = 5'h18;
  localparam logic [4:0] FRD_CODE_RSV_WR = 5'h19;

  // ****************************************
  // Second phase field positions
  // ****************************************
  localparam int FRD_B_REDIR_DIS = 31;
  localparam int FRD_B_LOGICAL_HI = 30;
  localparam int FRD_B_LOGICAL_LO = 29;
  localparam int FRD_B_PRIO_HI = 27;
  localparam int FRD_B_PRIO_LO = 24;
  localparam int FRD_B_PRIORITY_AGENT = 23;
  localparam int FRD_B_AGENT_HI = 22;
  localparam int FRD_B_AGENT_LO = 21;
  localparam int FRD_B_TRANS_HI = 20;
  localparam int FRD_B_TRANS_LO = 16;
  localparam int FRD_B_BE_HI = 15;
  localparam int FRD_B_BE_LO = 8;
  localparam int FRD_B_SMM = 7;
  localparam int FRD_B_FLAG6 = 6;
  localparam int FRD_B_FLAG5 = 5;
  localparam int FRD_B_DEFER_EN = 4;
  localparam int FRD_B_DPS = 3;

  localparam logic [7:0] FRD_BE_ALL = 8'hff;
  localparam logic [7:0] FRD_BE_NONE = 8'h00;
  localparam logic [1:0] FRD_INT_EOI = 2'h3;

  typedef enum logic [4:0] {
    FRD_K_UNSUPPORTED, FRD_K_NOP, FRD_K_READ_INV_LINE, FRD_K_ZERO_INV,
    FRD_K_CODE_READ, FRD_K_DATA_READ, FRD_K_LOCKED_READ, FRD_K_WRITE_LINE,
    FRD_K_WRITE_INV_LINE, FRD_K_LOCKED_WRITE, FRD_K_BRANCH_TRACE, FRD_K_INT_ACK,
    FRD_K_SHUTDOWN, FRD_K_FLUSH, FRD_K_HALT, FRD_K_SYNC, FRD_K_STOP_CLOCK,
    FRD_K_STOP_GRANT_ACK, FRD_K_SMM_ACK, FRD_K_TASK_PRIO, FRD_K_INTERRUPT,
    FRD_K_END_OF_INT, FRD_K_IO_READ, FRD_K_IO_WRITE, FRD_K_RSV_READ,
    FRD_K_DEFER_REPLY
  } frd_kind_t;

endpackage

// ---- logic/frd_request_decoder.sv ----
// Request phase decoder for processor transactions on the front-side bus
//
// The AHB-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module frd_request_decoder
  import frd_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic REQ_STROBE,
  input wire logic [4:0] REQUEST_PHASE_ONE,
  input wire logic [4:0] REQUEST_PHASE_TWO,
  input wire logic [39:3] ADDR_PHASE_TWO,
  input wire logic LOCK,
  input wire logic PARITY_ERR,
  input wire logic COH_DEFER_NEED,
  input wire logic REPLY_OUTSTANDING,
  output logic DEC_VALID,
  output frd_kind_t DEC_KIND,
  output logic [1:0] DEC_ADDRESS_SIZE_CODE,
  output logic DEC_DEFER,
  output logic DEC_USE_ID_STROBE,
  output logic DEC_ATOMIC,
  output logic DEC_NOP,
  output logic DEC_UNSUPPORTED,
  output logic DEC_LINE_INVALIDATE,
  output logic DEC_SMM_ALLOWED,
  output logic [7:0] DEC_BYTE_EN,
  output logic [1:0] DEC_LOGICAL_ID,
  output logic [1:0] DEC_AGENT_ID,
  output logic [4:0] DEC_TRANS_ID,
  output logic [3:0] DEC_TASK_PRIO,
  output logic DEC_REDIR_DISABLE,
  output logic [1:0] DEC_INT_TYPE
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic be_contiguous(input logic [7:0] be);
    logic [8:0] low;
    logic [7:0] filled;
    low = {1'b0, be} & (~{1'b0, be} + 9'h001);
    filled = be + low[7:0];
    be_contiguous = (be != FRD_BE_NONE) && ((filled & be) == FRD_BE_NONE);
  endfunction

  function automatic logic [FRD_ERR_W-1:0] w1c(input logic [FRD_ERR_W-1:0] cur,
      input logic [FRD_ERR_W-1:0] clr, input logic [FRD_ERR_W-1:0] set);
    w1c = (cur & ~clr) | set;
  endfunction

  // ****************************************
  // Register state
  // ****************************************
  logic [2:0] ctrl_q;
  logic [FRD_ERR_W-1:0] first_err_q;
  logic [FRD_ERR_W-1:0] next_err_q;
  logic [15:0] req_count_q;
  logic dp_write_q;
  logic [7:0] dp_addr_q;

  logic take;
  assign take = REQ_STROBE && ctrl_q[FRD_CTRL_EN_BIT];

  // ****************************************
  // Decode of the request
  // ****************************************
  frd_kind_t kind_d;
  logic defer_d;
  logic nop_d;
  logic unsup_d;
  logic inval_d;
  logic [1:0] int_type_d;
  logic f8_d;
  logic sym_d;
  logic deferrable;
  logic [2:0] low_code;
  logic [7:0] be;
  logic den;
  logic dps;

  // Bits 39:32, 28 and the data size code are never read
  assign low_code = REQUEST_PHASE_ONE[2:0];
  assign be = ADDR_PHASE_TWO[FRD_B_BE_HI:FRD_B_BE_LO];
  assign den = ADDR_PHASE_TWO[FRD_B_DEFER_EN];
  assign dps = ADDR_PHASE_TWO[FRD_B_DPS];

  always_comb begin
    kind_d = FRD_K_UNSUPPORTED;
    nop_d = 1'b0;
    inval_d = 1'b0;
    int_type_d = 2'h0;
    f8_d = 1'b0;
    case (low_code)
      FRD_MEM_RD_INV: begin
        // Ownership bit 5 plays no part in line reads
        if (be == FRD_BE_ALL) begin
          kind_d = FRD_K_READ_INV_LINE;
        end else if (be == FRD_BE_NONE) begin
          kind_d = FRD_K_ZERO_INV;
        end
      end
      FRD_MEM_RD_CODE, FRD_MEM_RD_DATA: begin
        if (LOCK) begin
          kind_d = FRD_K_LOCKED_READ;
        end else if (be_contiguous(be)) begin
          kind_d = (low_code == FRD_MEM_RD_CODE) ? FRD_K_CODE_READ : FRD_K_DATA_READ;
        end
      end
      FRD_MEM_WR_LINE: begin
        if (LOCK) begin
          kind_d = FRD_K_LOCKED_WRITE;
        end else if (!den && (be == FRD_BE_ALL || be == FRD_BE_NONE)) begin
          kind_d = FRD_K_WRITE_LINE;
          inval_d = ADDR_PHASE_TWO[FRD_B_FLAG6];
        end
      end
      FRD_MEM_WR_INV: kind_d = FRD_K_WRITE_INV_LINE;
      FRD_MEM_BRANCH: kind_d = FRD_K_BRANCH_TRACE;
      default: begin
        case (REQUEST_PHASE_ONE)
          FRD_CODE_DEFER_REPLY: begin
            kind_d = FRD_K_DEFER_REPLY;
            if (!REPLY_OUTSTANDING) begin
              nop_d = 1'b1;
              f8_d = 1'b1;
            end
          end
          FRD_CODE_INT_ACK: kind_d = FRD_K_INT_ACK;
          FRD_CODE_SPECIAL: begin
            case (be)
              8'h00: kind_d = FRD_K_NOP;
              8'h01: kind_d = FRD_K_SHUTDOWN;
              8'h02: kind_d = FRD_K_FLUSH;
              8'h03: kind_d = FRD_K_HALT;
              8'h04: kind_d = FRD_K_SYNC;
              8'h05: kind_d = FRD_K_STOP_CLOCK;
              8'h06: kind_d = FRD_K_STOP_GRANT_ACK;
              8'h07: kind_d = FRD_K_SMM_ACK;
              8'h08: kind_d = FRD_K_TASK_PRIO;
              default: kind_d = FRD_K_UNSUPPORTED;
            endcase
            nop_d = (be == FRD_BE_NONE);
          end
          FRD_CODE_INT: begin
            int_type_d = {ADDR_PHASE_TWO[FRD_B_FLAG6], ADDR_PHASE_TWO[FRD_B_FLAG5]};
            kind_d = (int_type_d == FRD_INT_EOI) ? FRD_K_END_OF_INT : FRD_K_INTERRUPT;
          end
          FRD_CODE_IO_RD: kind_d = LOCK ? FRD_K_UNSUPPORTED : FRD_K_IO_READ;
          FRD_CODE_IO_WR: kind_d = LOCK ? FRD_K_UNSUPPORTED : FRD_K_IO_WRITE;
          FRD_CODE_RSV_RD: begin
            kind_d = FRD_K_RSV_READ;
            nop_d = 1'b1;
          end
          FRD_CODE_RSV_WR: kind_d = FRD_K_BRANCH_TRACE;
          default: kind_d = FRD_K_UNSUPPORTED;
        endcase
      end
    endcase
  end

  always_comb begin
    unsup_d = (kind_d == FRD_K_UNSUPPORTED);
    // Write lines and replies complete in order
    deferrable = !unsup_d && !nop_d && (kind_d != FRD_K_WRITE_LINE)
      && (kind_d != FRD_K_DEFER_REPLY);
    defer_d = deferrable && (COH_DEFER_NEED || (den && ctrl_q[FRD_CTRL_DEFER_BIT]));
    sym_d = ADDR_PHASE_TWO[FRD_B_PRIORITY_AGENT];
  end

  // ****************************************
  // Decoded request outputs
  // ****************************************
  always_ff @(posedge CLK) begin
    if (RESET) begin
      DEC_VALID <= 1'b0;
    end else begin
      // Parity errors do not stop the decode
      DEC_VALID <= take;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      DEC_KIND <= FRD_K_UNSUPPORTED;
      DEC_ADDRESS_SIZE_CODE <= 2'h0;
      DEC_DEFER <= 1'b0;
      DEC_USE_ID_STROBE <= 1'b0;
      DEC_ATOMIC <= 1'b0;
      DEC_NOP <= 1'b0;
      DEC_UNSUPPORTED <= 1'b0;
      DEC_LINE_INVALIDATE <= 1'b0;
      DEC_SMM_ALLOWED <= 1'b0;
      DEC_BYTE_EN <= 8'h00;
      DEC_LOGICAL_ID <= 2'h0;
      DEC_AGENT_ID <= 2'h0;
      DEC_TRANS_ID <= 5'h00;
      DEC_TASK_PRIO <= 4'h0;
      DEC_REDIR_DISABLE <= 1'b0;
      DEC_INT_TYPE <= 2'h0;
    end else if (take) begin
      DEC_KIND <= kind_d;
      DEC_ADDRESS_SIZE_CODE <= REQUEST_PHASE_ONE[4:3];
      DEC_DEFER <= defer_d;
      DEC_USE_ID_STROBE <= defer_d && dps;
      DEC_ATOMIC <= LOCK && !unsup_d;
      DEC_NOP <= nop_d;
      DEC_UNSUPPORTED <= unsup_d;
      DEC_LINE_INVALIDATE <= inval_d;
      // Evictions of cacheable management memory pass without bit 7
      DEC_SMM_ALLOWED <= ADDR_PHASE_TWO[FRD_B_SMM]
        || ((kind_d == FRD_K_WRITE_LINE) && ctrl_q[FRD_CTRL_SMM_CACHE_BIT]);
      DEC_BYTE_EN <= be;
      DEC_LOGICAL_ID <= ADDR_PHASE_TWO[FRD_B_LOGICAL_HI:FRD_B_LOGICAL_LO];
      DEC_AGENT_ID <= ADDR_PHASE_TWO[FRD_B_AGENT_HI:FRD_B_AGENT_LO];
      DEC_TRANS_ID <= ADDR_PHASE_TWO[FRD_B_TRANS_HI:FRD_B_TRANS_LO];
      // Caching attributes share these bits and are dropped
      DEC_TASK_PRIO <= (kind_d == FRD_K_TASK_PRIO)
        ? ADDR_PHASE_TWO[FRD_B_PRIO_HI:FRD_B_PRIO_LO] : 4'h0;
      DEC_REDIR_DISABLE <= (kind_d == FRD_K_TASK_PRIO)
        && ADDR_PHASE_TWO[FRD_B_REDIR_DIS];
      DEC_INT_TYPE <= int_type_d;
    end
  end

  // ****************************************
  // Error logging
  // ****************************************
  logic [FRD_ERR_W-1:0] err_set;
  logic [FRD_ERR_W-1:0] first_clr;
  logic [FRD_ERR_W-1:0] next_clr;
  logic first_empty;

  always_comb begin
    err_set = '0;
    if (take) begin
      err_set[FRD_ERR_F4] = PARITY_ERR;
      err_set[FRD_ERR_F8] = f8_d || (COH_DEFER_NEED && !den && deferrable);
      err_set[FRD_ERR_UNSUP] = unsup_d;
      err_set[FRD_ERR_SYM] = sym_d;
    end
  end

  assign first_empty = (first_err_q == '0);
  assign first_clr = (dp_write_q && dp_addr_q == FRD_REG_FIRST_ERR)
    ? HWDATA[FRD_ERR_W-1:0] : '0;
  assign next_clr = (dp_write_q && dp_addr_q == FRD_REG_NEXT_ERR)
    ? HWDATA[FRD_ERR_W-1:0] : '0;

  // New errors win over a simultaneous clear
  always_ff @(posedge CLK) begin
    if (RESET) begin
      first_err_q <= '0;
    end else begin
      first_err_q <= w1c(first_err_q, first_clr, first_empty ? err_set : '0);
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      next_err_q <= '0;
    end else begin
      next_err_q <= w1c(next_err_q, next_clr, first_empty ? '0 : err_set);
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      req_count_q <= 16'h0000;
    end else if (take) begin
      req_count_q <= req_count_q + 16'h0001;
    end
  end

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  logic addr_phase;
  assign addr_phase = HSEL && HREADY && HTRANS[1];

  always_ff @(posedge CLK) begin
    if (RESET) begin
      dp_write_q <= 1'b0;
      dp_addr_q <= 8'h00;
    end else begin
      dp_write_q <= addr_phase && HWRITE;
      dp_addr_q <= addr_phase ? HADDR[7:0] : 8'h00;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      ctrl_q <= FRD_CTRL_RESET;
    end else if (dp_write_q && dp_addr_q == FRD_REG_CTRL) begin
      ctrl_q <= HWDATA[2:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      HRDATA <= 32'h0000_0000;
    end else if (addr_phase && !HWRITE) begin
      case (HADDR[7:0])
        FRD_REG_CTRL: HRDATA <= {29'h0, ctrl_q};
        FRD_REG_FIRST_ERR: HRDATA <= {28'h0, first_err_q};
        FRD_REG_NEXT_ERR: HRDATA <= {28'h0, next_err_q};
        FRD_REG_STATUS: HRDATA <= {11'h000, DEC_KIND, req_count_q};
        default: HRDATA <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  logic [1:0] agent_in;
  logic [4:0] trans_in;
  logic redir_in;
  assign agent_in = ADDR_PHASE_TWO[FRD_B_AGENT_HI:FRD_B_AGENT_LO];
  assign trans_in = ADDR_PHASE_TWO[FRD_B_TRANS_HI:FRD_B_TRANS_LO];
  assign redir_in = ADDR_PHASE_TWO[FRD_B_REDIR_DIS];

  sequence s_take;
    take;
  endsequence

  sequence s_logged(int bitn);
    first_err_q[bitn] || next_err_q[bitn];
  endsequence

  property p_write_line_no_defer;
    DEC_VALID && DEC_KIND == FRD_K_WRITE_LINE |-> !DEC_DEFER;
  endproperty
  a_write_line_no_defer: assert property (p_write_line_no_defer)
    else $error("write line was deferred");

  property p_stray_reply;
    s_take ##0 (REQUEST_PHASE_ONE == FRD_CODE_DEFER_REPLY && !REPLY_OUTSTANDING)
      |=> DEC_NOP and s_logged(FRD_ERR_F8);
  endproperty
  a_stray_reply: assert property (p_stray_reply)
    else $error("stray deferred reply not handled as no-op with F8");

  property p_forced_defer;
    s_take ##0 (COH_DEFER_NEED && !den && deferrable) |=> DEC_DEFER ##0 s_logged(FRD_ERR_F8);
  endproperty
  a_forced_defer: assert property (p_forced_defer)
    else $error("coherency defer without enable not forced");

  property p_unsup_logged;
    DEC_VALID && DEC_UNSUPPORTED |-> s_logged(FRD_ERR_UNSUP);
  endproperty
  a_unsup_logged: assert property (p_unsup_logged)
    else $error("unsupported request not logged");

  property p_parity_continue;
    s_take ##0 PARITY_ERR |=> DEC_VALID and s_logged(FRD_ERR_F4);
  endproperty
  a_parity_continue: assert property (p_parity_continue)
    else $error("parity error stopped decode or was not logged");

  property p_ids_capture;
    s_take |=> DEC_AGENT_ID == $past(agent_in) && DEC_TRANS_ID == $past(trans_in);
  endproperty
  a_ids_capture: assert property (p_ids_capture)
    else $error("identifiers not captured");

  property p_redir_only_prio;
    s_take ##0 (REQUEST_PHASE_ONE == FRD_CODE_SPECIAL && be == 8'h08)
      |=> DEC_KIND == FRD_K_TASK_PRIO && DEC_REDIR_DISABLE == $past(redir_in);
  endproperty
  a_redir_only_prio: assert property (p_redir_only_prio)
    else $error("priority update decode wrong");

  property p_ids_needs_defer;
    DEC_USE_ID_STROBE |-> DEC_DEFER;
  endproperty
  a_ids_needs_defer: assert property (p_ids_needs_defer)
    else $error("id strobe without deferral");

  property p_locked_io;
    s_take ##0 (LOCK && REQUEST_PHASE_ONE == FRD_CODE_IO_RD)
      |=> DEC_UNSUPPORTED && !DEC_ATOMIC;
  endproperty
  a_locked_io: assert property (p_locked_io)
    else $error("locked I/O read accepted");

  property p_int_type_zero;
    DEC_VALID && DEC_KIND != FRD_K_INTERRUPT && DEC_KIND != FRD_K_END_OF_INT
      |-> DEC_INT_TYPE == 2'h0;
  endproperty
  a_int_type_zero: assert property (p_int_type_zero)
    else $error("interrupt type on non-interrupt request");

endmodule
`default_nettype wire

// ---- testbench/frd_cpu_model.sv ----
// Processor agent model that drives request phases into the decoder
`timescale 1ns/1ps
`default_nettype none
module frd_cpu_model (
  input wire logic clk,
  input wire logic go,
  input wire logic [4:0] code,
  input wire logic [39:3] addr,
  input wire logic lock,
  output logic strobe,
  output logic [4:0] phase_one,
  output logic [4:0] phase_two,
  output logic [39:3] addr_two,
  output logic lock_o
);
  initial begin
    strobe = 1'b0;
    phase_one = 5'h00;
    phase_two = 5'h00;
    addr_two = '0;
    lock_o = 1'b0;
  end
  // Fields scrambled outside the strobe cycle
  always @(posedge clk) begin
    strobe <= go;
    phase_one <= go ? code : ~phase_one;
    phase_two <= 5'($urandom);
    addr_two <= go ? {addr[39:24], 1'b0, addr[22:3]} : ~addr_two;
    lock_o <= go & lock;
  end
endmodule
`default_nettype wire

// ---- testbench/fsb_request_decoder_tb.sv ----
// Self-checking testbench for the request phase decoder
`timescale 1ns/1ps
`default_nettype none
module fsb_request_decoder_tb;
  import frd_pkg::*;
  logic CLK = 0, RESET = 1, HSEL = 0, HWRITE = 0, HREADY, HREADYOUT, HRESP;
  logic [31:0] HADDR = 0, HWDATA = 0, HRDATA;
  logic [1:0] HTRANS = 0;
  logic [2:0] HSIZE = 3'h2;
  logic REQ_STROBE, LOCK, PARITY_ERR = 0, COH_DEFER_NEED = 0, REPLY_OUTSTANDING = 1;
  logic [4:0] REQUEST_PHASE_ONE, REQUEST_PHASE_TWO, DEC_TRANS_ID;
  logic [39:3] ADDR_PHASE_TWO, a;
  logic DEC_VALID, DEC_DEFER, DEC_USE_ID_STROBE, DEC_ATOMIC, DEC_NOP, DEC_UNSUPPORTED;
  logic DEC_LINE_INVALIDATE, DEC_SMM_ALLOWED, DEC_REDIR_DISABLE;
  frd_kind_t DEC_KIND;
  logic [1:0] DEC_ADDRESS_SIZE_CODE, DEC_LOGICAL_ID, DEC_AGENT_ID, DEC_INT_TYPE;
  logic [7:0] DEC_BYTE_EN;
  logic [3:0] DEC_TASK_PRIO;
  logic go = 0, lk = 0;
  logic [4:0] code = 0;
  logic [39:3] addr = '0;
  logic [31:0] rd;
  frd_kind_t spk [9];
  int n_mismatch = 0, checked = 0;
  int n_rq = 0;
  assign HREADY = HREADYOUT;
  initial forever #25 CLK = ~CLK;
  frd_cpu_model cpu (.clk(CLK), .go(go), .code(code), .addr(addr), .lock(lk),
    .strobe(REQ_STROBE), .phase_one(REQUEST_PHASE_ONE), .phase_two(REQUEST_PHASE_TWO),
    .addr_two(ADDR_PHASE_TWO), .lock_o(LOCK));
  frd_request_decoder uut (.CLK(CLK), .RESET(RESET), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .REQ_STROBE(REQ_STROBE),
    .REQUEST_PHASE_ONE(REQUEST_PHASE_ONE), .REQUEST_PHASE_TWO(REQUEST_PHASE_TWO),
    .ADDR_PHASE_TWO(ADDR_PHASE_TWO), .LOCK(LOCK), .PARITY_ERR(PARITY_ERR),
    .COH_DEFER_NEED(COH_DEFER_NEED), .REPLY_OUTSTANDING(REPLY_OUTSTANDING),
    .DEC_VALID(DEC_VALID), .DEC_KIND(DEC_KIND), .DEC_ADDRESS_SIZE_CODE(DEC_ADDRESS_SIZE_CODE),
    .DEC_DEFER(DEC_DEFER), .DEC_USE_ID_STROBE(DEC_USE_ID_STROBE), .DEC_ATOMIC(DEC_ATOMIC),
    .DEC_NOP(DEC_NOP), .DEC_UNSUPPORTED(DEC_UNSUPPORTED),
    .DEC_LINE_INVALIDATE(DEC_LINE_INVALIDATE), .DEC_SMM_ALLOWED(DEC_SMM_ALLOWED),
    .DEC_BYTE_EN(DEC_BYTE_EN), .DEC_LOGICAL_ID(DEC_LOGICAL_ID), .DEC_AGENT_ID(DEC_AGENT_ID),
    .DEC_TRANS_ID(DEC_TRANS_ID), .DEC_TASK_PRIO(DEC_TASK_PRIO),
    .DEC_REDIR_DISABLE(DEC_REDIR_DISABLE), .DEC_INT_TYPE(DEC_INT_TYPE));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    HSEL <= 1; HADDR <= {24'h0, ad}; HTRANS <= 2'h2; HWRITE <= w;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    HSEL <= 0; HTRANS <= 2'h0; HWDATA <= d;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    rd = HRDATA;
  endtask
  task automatic errs(input logic [31:0] exp);
    bus(0, FRD_REG_FIRST_ERR, 0);
    chk(rd, exp);
    bus(1, FRD_REG_FIRST_ERR, 32'hf);
    bus(1, FRD_REG_NEXT_ERR, 32'hf);
  endtask
  task automatic rq(input logic [4:0] c, input logic [39:3] ad, input logic l = 0);
    int n;
    n = 0;
    n_rq++;
    code <= c; addr <= ad; lk <= l; go <= 1;
    @(posedge CLK);
    go <= 0;
    do begin @(negedge CLK); n++; end while (DEC_VALID !== 1'b1 && n < 8);
    if (n >= 8) chk(0, 1);
    chk(DEC_LOGICAL_ID, ad[30:29]);
    chk({DEC_AGENT_ID, DEC_TRANS_ID}, ad[22:16]);
    chk(DEC_BYTE_EN, ad[15:8]);
    @(posedge CLK);
  endtask
  function automatic logic [39:3] mk(input logic [7:0] be, input logic [4:0] ex);
    return {16'($urandom), 1'b0, 7'($urandom), be, ex};
  endfunction
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    spk = '{FRD_K_NOP, FRD_K_SHUTDOWN, FRD_K_FLUSH, FRD_K_HALT, FRD_K_SYNC,
      FRD_K_STOP_CLOCK, FRD_K_STOP_GRANT_ACK, FRD_K_SMM_ACK, FRD_K_TASK_PRIO};
    void'($urandom(87));
    repeat (5) @(posedge CLK);
    RESET <= 0;
    @(posedge CLK);
    bus(0, FRD_REG_CTRL, 0);
    chk(rd, 32'h3);
    errs(0);
    $display("test reset done");
    COH_DEFER_NEED <= 1;
    rq(5'h0f, mk(8'hff, 5'b01000));
    chk(DEC_KIND, FRD_K_WRITE_LINE);
    chk(DEC_ADDRESS_SIZE_CODE, 2'h1);
    chk(DEC_DEFER, 0);
    chk(DEC_LINE_INVALIDATE, 1);
    rq(5'h04, mk(8'h0f, 5'b00001));
    chk({DEC_DEFER, DEC_USE_ID_STROBE}, 2'h3);
    errs(32'h2);
    COH_DEFER_NEED <= 0;
    REPLY_OUTSTANDING <= 0;
    rq(5'h00, mk(8'h00, 5'b0));
    chk(DEC_NOP, 1);
    errs(32'h2);
    REPLY_OUTSTANDING <= 1;
    rq(5'h01, mk(8'h09, 5'b0));
    chk(DEC_UNSUPPORTED, 1);
    errs(32'h4);
    PARITY_ERR <= 1;
    rq(5'h16, mk(8'h0f, 5'b10000));
    PARITY_ERR <= 0;
    chk(DEC_KIND, FRD_K_DATA_READ);
    chk(DEC_SMM_ALLOWED, 1);
    errs(32'h1);
    $display("test errors done");
    for (int i = 0; i < 9; i++) begin
      a = mk(8'(i), 5'b0);
      rq(5'h01, a);
      chk(DEC_KIND, spk[i]);
      chk({DEC_REDIR_DISABLE, DEC_TASK_PRIO}, i == 8 ? {a[31], a[27:24]} : 0);
    end
    rq(5'h02, mk(8'hff, 5'b00100));
    chk(DEC_KIND, FRD_K_READ_INV_LINE);
    rq(5'h02, mk(8'h00, 5'b00100));
    chk(DEC_KIND, FRD_K_ZERO_INV);
    rq(5'h06, mk(8'h3c, {2'($urandom), 3'b100}), 1);
    chk({DEC_KIND, DEC_ATOMIC}, {FRD_K_LOCKED_READ, 1'b1});
    rq(5'h10, mk(8'h0f, 5'b00011), 1);
    chk({DEC_UNSUPPORTED, DEC_ATOMIC}, 2'h2);
    rq(5'h09, mk(8'h0f, 5'b00100));
    chk({DEC_KIND, DEC_INT_TYPE}, {FRD_K_INTERRUPT, 2'h1});
    rq(5'h09, mk(8'h01, 5'b01100));
    chk({DEC_KIND, DEC_INT_TYPE}, {FRD_K_END_OF_INT, 2'h3});
    rq(5'h16, mk(8'h0f, 5'b00100));
    chk({DEC_SMM_ALLOWED, DEC_INT_TYPE, DEC_TASK_PRIO}, 0);
    rq(5'h18, mk(8'h0f, 5'b0));
    chk({DEC_KIND, DEC_NOP}, {FRD_K_RSV_READ, 1'b1});
    rq(5'h19, mk(8'hff, 5'b0));
    chk(DEC_KIND, FRD_K_BRANCH_TRACE);
    errs(32'h4);
    bus(1, FRD_REG_CTRL, 0);
    code <= 5'h06; addr <= mk(8'h0f, 5'b0); go <= 1;
    @(posedge CLK);
    go <= 0;
    repeat (3) begin @(negedge CLK); chk(DEC_VALID, 0); end
    @(posedge CLK);
    bus(1, FRD_REG_CTRL, 32'h5);
    rq(5'h07, mk(8'h0f, 5'b01000), 1);
    chk({DEC_KIND, DEC_ATOMIC}, {FRD_K_LOCKED_WRITE, 1'b1});
    rq(5'h07, mk(8'hff, 5'b00010));
    chk({DEC_UNSUPPORTED, DEC_DEFER}, 2'h2);
    errs(32'h4);
    rq(5'h07, mk(8'h00, 5'b0));
    chk({DEC_KIND, DEC_SMM_ALLOWED}, {FRD_K_WRITE_LINE, 1'b1});
    rq(5'h04, mk(8'h01, 5'b00011));
    chk({DEC_DEFER, DEC_USE_ID_STROBE}, 2'h0);
    bus(0, FRD_REG_STATUS, 0);
    chk(rd, {11'h000, FRD_K_CODE_READ, n_rq[15:0]});
    $display("test decode done");
    give_verdict();
  end
  initial begin
    #500000;
    n_mismatch++;
    give_verdict();
  end
endmodule
`default_nettype wire
